// >>> src/pofi_unit.sv
// Operation
// - unsigned double operand is 32 bits from two consecutive registers, named by low one.
// - named register gives low 16 bits, the next register gives high 16 bits.
// - low register of a pair may sit at odd or even address.
// - unsigned double value spans 0 to 4294967295, high register is upper half.
// - signed double value is two's complement, -2147483648 to 2147483647.
// - sign is top bit of high register, all 32 bits read as two's complement.
// - double bcd operand is eight digits over two registers, at most 99999999.
// - low register holds four low digits, next register four high digits.
// - bcd add, subtract, multiply and divide work on bcd operands directly.
// - indexed address is base address plus signed index register contents.
// - three index registers, each signed 16 bits, -32768 to 32767.
// - all three index registers behave alike, none has special duties.
// - index registers load only as ordinary destinations of instructions.
// - double result into index registers: first pairs with second, second with third.
// - pulse contact true once on off-to-on, until same instruction next scan.
// - increment adds one to operand and writes sum back to it.
// - multiply writes the full product into a double-length destination pair.
// - copy moves source operand contents into destination operand.
// - encode writes position of highest set bit of source into destination.
// - indexed address outside register area suppresses instruction, sets both flags.
`timescale 1ns/10ps

module pofi_unit #(
    parameter int REG_DEPTH = 4096
) (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           req_valid,
    input  wire pofi_pkg::pofi_req_t            req,
    output pofi_pkg::pofi_rsp_t                 rsp,
    input  wire logic                           flag_clr,
    output logic                                boundary_error_flag_a,
    output logic                                boundary_error_flag_b,
    input  wire logic [pofi_pkg::ADDR_W-1:0]    peek_addr,
    output logic      [pofi_pkg::DATA_W-1:0]    peek_data
);

    localparam int AW = $clog2(REG_DEPTH);
    localparam int EW = pofi_pkg::ADDR_W + 2;
    localparam int DW = pofi_pkg::DATA_W;
    localparam int NC = 2 ** pofi_pkg::CONTACT_W;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_n_q;

    // assert at once, release two edges later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DW-1:0]            rf_q   [REG_DEPTH];
    logic [DW-1:0]            ixr_q  [pofi_pkg::NUM_IXR];
    logic [NC-1:0]            prev_q;

    // ------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------
    // same path for I, J and K, nothing is special about one
    function automatic logic signed [EW-1:0] ix_off(
        input pofi_pkg::pofi_ixsel_t sel
    );
        logic [DW-1:0] v;
        v = '0;
        case (sel)
            pofi_pkg::IX_I: v = ixr_q[0];
            pofi_pkg::IX_J: v = ixr_q[1];
            pofi_pkg::IX_K: v = ixr_q[2];
            default:        v = '0;
        endcase
        return $signed({{(EW-DW){v[DW-1]}}, v});
    endfunction

    function automatic logic signed [EW-1:0] ea_f(
        input logic [pofi_pkg::ADDR_W-1:0] base,
        input pofi_pkg::pofi_ixsel_t       sel
    );
        return $signed({2'b00, base}) + ix_off(sel);
    endfunction

    // a pair needs its high word inside the area too
    function automatic logic oob_f(
        input logic signed [EW-1:0] ea,
        input logic                 dbl
    );
        return (ea < 0) || (int'(ea) + int'(dbl) >= REG_DEPTH);
    endfunction

    logic signed [EW-1:0] ea_a;
    logic signed [EW-1:0] ea_b;
    logic signed [EW-1:0] ea_d;
    logic [AW-1:0]        ad_a;
    logic [AW-1:0]        ad_b;
    logic [AW-1:0]        ad_d;
    logic [AW-1:0]        ad_a1;
    logic [AW-1:0]        ad_b1;
    logic [AW-1:0]        ad_d1;

    assign ea_a  = ea_f(req.a_base, req.a_ix);
    assign ea_b  = ea_f(req.b_base, req.b_ix);
    assign ea_d  = ea_f(req.d_base, req.d_ix);
    assign ad_a  = ea_a[AW-1:0];
    assign ad_b  = ea_b[AW-1:0];
    assign ad_d  = ea_d[AW-1:0];
    // odd or even low address, no alignment
    assign ad_a1 = ad_a + AW'(1);
    assign ad_b1 = ad_b + AW'(1);
    assign ad_d1 = ad_d + AW'(1);

    // ------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------
    localparam int DBL_W_L = pofi_pkg::DBL_W;

    logic                  wr_dbl;
    logic                  a_dbl;
    logic [DW-1:0]         a_lo;
    logic [DW-1:0]         b_lo;
    logic [DBL_W_L-1:0]    a_val;
    logic [DBL_W_L-1:0]    b_val;
    logic [DBL_W_L-1:0]    d_val;
    logic [1:0]            dl;
    logic                  ixr_dst;
    logic                  ixr_pair_bad;
    // multiply always yields a pair
    assign wr_dbl  = req.dbl || (req.op == pofi_pkg::OP_MUL);
    // multiply sources are single words
    assign a_dbl   = req.dbl && (req.op != pofi_pkg::OP_MUL);
    assign a_lo    = rf_q[ad_a];
    assign b_lo    = rf_q[ad_b];
    assign ixr_dst = (req.d_ixr != pofi_pkg::IX_NONE);
    assign dl      = 2'(req.d_ixr) - 2'h1;
    // only I with J and J with K form a pair
    assign ixr_pair_bad = ixr_dst && wr_dbl && (req.d_ixr == pofi_pkg::IX_K);

    // low word at the named address, high word at the next one
    always_comb begin
        if (req.a_imm) begin
            a_val = req.imm;
        end else if (a_dbl) begin
            a_val = {rf_q[ad_a1], a_lo};
        end else begin
            // single words widen by sign for signed use
            a_val = {{DW{req.sgn & a_lo[DW-1]}}, a_lo};
        end
    end

    always_comb begin
        if (req.b_imm) begin
            b_val = req.imm;
        end else if (a_dbl) begin
            b_val = {rf_q[ad_b1], b_lo};
        end else begin
            b_val = {{DW{req.sgn & b_lo[DW-1]}}, b_lo};
        end
    end

    // destination contents, read back by increment
    always_comb begin
        if (ixr_dst) begin
            d_val = {ixr_q[dl == 2'h0 ? 2'h1 : 2'h2], ixr_q[dl]};
        end else begin
            d_val = {rf_q[ad_d1], rf_q[ad_d]};
        end
        if (!wr_dbl) begin
            d_val[DBL_W_L-1:DW] = {DW{req.sgn & d_val[DW-1]}};
        end
    end

    // ------------------------------------------------------------
    // boundary check
    // ------------------------------------------------------------
    logic a_used;
    logic b_used;
    logic d_used;
    logic bad;

    assign a_used = !req.a_imm && (req.op != pofi_pkg::OP_NOP)
                 && (req.op != pofi_pkg::OP_PULSE)
                 && (req.op != pofi_pkg::OP_INC);
    assign b_used = !req.b_imm && ((req.op == pofi_pkg::OP_MUL)
                 || (req.op == pofi_pkg::OP_BADD)
                 || (req.op == pofi_pkg::OP_BSUB)
                 || (req.op == pofi_pkg::OP_BMUL)
                 || (req.op == pofi_pkg::OP_BDIV));
    assign d_used = !ixr_dst && (req.op != pofi_pkg::OP_NOP)
                 && (req.op != pofi_pkg::OP_PULSE);

    // any operand out of the area cancels the whole instruction
    assign bad = (a_used && oob_f(ea_a, a_dbl))
              || (b_used && oob_f(ea_b, a_dbl))
              || (d_used && oob_f(ea_d, wr_dbl))
              || ixr_pair_bad;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic [3:0]          hsb_pos;
    logic [DBL_W_L-1:0]  bcd_y;
    logic [DBL_W_L-1:0]  mul_y;
    logic [DBL_W_L-1:0]  res;
    logic                wr_en;
    logic                pulse;

    pofi_msb_encoder #(
        .W   (DW)
    ) u_hsb (
        .src (a_val[DW-1:0]),
        .pos (hsb_pos),
        .any ()
    );

    pofi_bcd_alu u_bcd (
        .a_bcd    (a_val),
        .b_bcd    (b_val),
        .op       (req.op),
        .y_bcd    (bcd_y),
        .div_zero ()
    );

    // low half of the widened product is exact for both signs
    assign mul_y = {{DW{req.sgn & a_val[DW-1]}}, a_val[DW-1:0]}
                 * {{DW{req.sgn & b_val[DW-1]}}, b_val[DW-1:0]};

    // new contact level against the one seen last execution
    assign pulse = req.contact_in && !prev_q[req.contact];

    always_comb begin
        wr_en = req_valid && !bad;
        case (req.op)
            pofi_pkg::OP_COPY:  res = a_val;
            pofi_pkg::OP_INC:   res = d_val + pofi_pkg::INC_STEP;
            pofi_pkg::OP_MUL:   res = mul_y;
            pofi_pkg::OP_HSB:   res = {28'h0, hsb_pos};
            pofi_pkg::OP_BADD,
            pofi_pkg::OP_BSUB,
            pofi_pkg::OP_BMUL,
            pofi_pkg::OP_BDIV:  res = bcd_y;
            pofi_pkg::OP_PULSE: begin
                res   = {31'h0, pulse};
                wr_en = 1'b0;
            end
            default: begin
                res   = '0;
                wr_en = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // register area write
    // ------------------------------------------------------------
    // no reset on the array: contents are program data, not control
    always_ff @(posedge clk) begin
        if (wr_en && !ixr_dst) begin
            rf_q[ad_d] <= res[DW-1:0];
            if (wr_dbl) begin
                rf_q[ad_d1] <= res[DBL_W_L-1:DW];
            end
        end
    end

    // ------------------------------------------------------------
    // index registers
    // ------------------------------------------------------------
    // loaded only as plain destinations, no load opcode exists
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            for (int i = 0; i < pofi_pkg::NUM_IXR; i++) begin
                ixr_q[i] <= pofi_pkg::IXR_RST;
            end
        end else if (wr_en && ixr_dst) begin
            ixr_q[dl] <= res[DW-1:0];
            if (wr_dbl) begin
                ixr_q[dl + 2'h1] <= res[DBL_W_L-1:DW];
            end
        end
    end

    // ------------------------------------------------------------
    // pulse contact history
    // ------------------------------------------------------------
    // history moves only when the contact runs, so the pulse holds
    // for one full scan whatever the clock count between scans
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            prev_q <= '0;
        end else if (req_valid && req.op == pofi_pkg::OP_PULSE) begin
            prev_q[req.contact] <= req.contact_in;
        end
    end

    // ------------------------------------------------------------
    // answer and status flags
    // ------------------------------------------------------------
    logic flag_a_q;
    logic flag_b_q;

    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            rsp <= '0;
        end else begin
            rsp.done        <= req_valid;
            rsp.suppressed  <= req_valid && bad;
            rsp.result      <= req_valid ? res : pofi_pkg::RES_RST;
            if (req_valid && req.op == pofi_pkg::OP_PULSE) begin
                rsp.contact_out <= pulse;
            end
        end
    end

    // sticky; a new error in the clear cycle wins over the clear
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else if (req_valid && bad) begin
            flag_a_q <= 1'b1;
            flag_b_q <= 1'b1;
        end else if (flag_clr) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end
    end

    assign boundary_error_flag_a = flag_a_q;
    assign boundary_error_flag_b = flag_b_q;

    // ------------------------------------------------------------
    // observation port
    // ------------------------------------------------------------
    // addresses past the area read zero
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            peek_data <= '0;
        end else if (int'(peek_addr) < REG_DEPTH) begin
            peek_data <= rf_q[peek_addr[AW-1:0]];
        end else begin
            peek_data <= '0;
        end
    end

endmodule // pofi_unit

// >>> src/pofi_pkg.sv
package pofi_pkg;

    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int DATA_W      = 16;
    localparam int DBL_W       = 32;
    localparam int ADDR_W      = 16;
    localparam int NUM_IXR     = 3;
    localparam int CONTACT_W   = 4;
    localparam int BCD_DIGITS  = 8;
    localparam int BCD_BIN_W   = 27;
    localparam int BCD_PROD_W  = 54;

    // ------------------------------------------------------------
    // value and reset constants
    // ------------------------------------------------------------
    localparam logic [BCD_BIN_W-1:0] BCD_MOD   = 27'h5f5e100; // 10^8
    localparam logic [DATA_W-1:0]    IXR_RST   = 16'h0000;
    localparam logic [DBL_W-1:0]     RES_RST   = 32'h0000_0000;
    localparam logic [DBL_W-1:0]     INC_STEP  = 32'h0000_0001;

    // ------------------------------------------------------------
    // instruction primitives
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP,
        OP_COPY,
        OP_INC,
        OP_MUL,
        OP_HSB,
        OP_BADD,
        OP_BSUB,
        OP_BMUL,
        OP_BDIV,
        OP_PULSE
    } pofi_op_t;

    // index register select; none means direct addressing
    typedef enum logic [1:0] {
        IX_NONE,
        IX_I,
        IX_J,
        IX_K
    } pofi_ixsel_t;

    // one instruction from the sequencer
    typedef struct packed {
        pofi_op_t               op;
        logic                   dbl;
        logic                   sgn;
        logic                   a_imm;
        logic [ADDR_W-1:0]      a_base;
        pofi_ixsel_t            a_ix;
        logic                   b_imm;
        logic [ADDR_W-1:0]      b_base;
        pofi_ixsel_t            b_ix;
        logic [DBL_W-1:0]       imm;
        logic [ADDR_W-1:0]      d_base;
        pofi_ixsel_t            d_ix;
        pofi_ixsel_t            d_ixr;
        logic [CONTACT_W-1:0]   contact;
        logic                   contact_in;
    } pofi_req_t;

    // answer one cycle after the request
    typedef struct packed {
        logic                   done;
        logic                   suppressed;
        logic [DBL_W-1:0]       result;
        logic                   contact_out;
    } pofi_rsp_t;

endpackage

// >>> src/pofi_msb_encoder.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// highest set bit position
// ------------------------------------------------------------
module pofi_msb_encoder #(
    parameter int W = 16
) (
    input  wire logic [W-1:0]         src,
    output logic      [$clog2(W)-1:0] pos,
    output logic                      any
);

    // later (higher) bits overwrite, so the top one wins
    always_comb begin
        pos = '0;
        any = 1'b0;
        for (int i = 0; i < W; i++) begin
            if (src[i]) begin
                pos = ($clog2(W))'(i);
                any = 1'b1;
            end
        end
    end

endmodule // pofi_msb_encoder

// >>> src/pofi_bcd_alu.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// eight digit bcd arithmetic, operands stay in bcd at the ports
// ------------------------------------------------------------
module pofi_bcd_alu (
    input  wire logic [pofi_pkg::DBL_W-1:0] a_bcd,
    input  wire logic [pofi_pkg::DBL_W-1:0] b_bcd,
    input  wire pofi_pkg::pofi_op_t         op,
    output logic      [pofi_pkg::DBL_W-1:0] y_bcd,
    output logic                            div_zero
);

    localparam int BW = pofi_pkg::BCD_BIN_W;
    localparam int PW = pofi_pkg::BCD_PROD_W;

    function automatic logic [BW-1:0] to_bin(input logic [31:0] d);
        logic [BW-1:0] acc;
        acc = '0;
        for (int i = pofi_pkg::BCD_DIGITS - 1; i >= 0; i--) begin
            acc = BW'(acc * BW'(10)) + BW'(d[4*i +: 4]);
        end
        return acc;
    endfunction

    // double dabble; inputs are always below 10^8
    function automatic logic [31:0] to_bcd(input logic [BW-1:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = BW - 1; i >= 0; i--) begin
            for (int k = 0; k < pofi_pkg::BCD_DIGITS; k++) begin
                if (r[4*k +: 4] > 4'h4) begin
                    r[4*k +: 4] = r[4*k +: 4] + 4'h3;
                end
            end
            r = {r[30:0], v[i]};
        end
        return r;
    endfunction

    logic [BW-1:0] a_bin;
    logic [BW-1:0] b_bin;
    logic [BW:0]   sum;
    logic [PW-1:0] prod;
    logic [BW-1:0] y_bin;

    assign a_bin = to_bin(a_bcd);
    assign b_bin = to_bin(b_bcd);
    assign sum   = {1'b0, a_bin} + {1'b0, b_bin};
    assign prod  = PW'(a_bin) * PW'(b_bin);

    // results wrap modulo 10^8, a negative difference in tens complement
    always_comb begin
        div_zero = 1'b0;
        case (op)
            pofi_pkg::OP_BADD: begin
                y_bin = (sum >= {1'b0, pofi_pkg::BCD_MOD})
                      ? BW'(sum - {1'b0, pofi_pkg::BCD_MOD}) : BW'(sum);
            end
            pofi_pkg::OP_BSUB: begin
                y_bin = (a_bin >= b_bin) ? BW'(a_bin - b_bin)
                      : BW'(a_bin + pofi_pkg::BCD_MOD - b_bin);
            end
            pofi_pkg::OP_BMUL: begin
                y_bin = BW'(prod % PW'(pofi_pkg::BCD_MOD));
            end
            pofi_pkg::OP_BDIV: begin
                div_zero = (b_bin == '0);
                y_bin    = div_zero ? '0 : BW'(a_bin / b_bin);
            end
            default: begin
                y_bin = '0;
            end
        endcase
    end

    assign y_bcd = to_bcd(y_bin);

endmodule // pofi_bcd_alu

// >>> sim/pofi_unit_props.sv
`timescale 1ns/10ps

// --------------------
// port checker for the operand unit
// --------------------
module pofi_unit_props (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                req_valid,
    input wire pofi_pkg::pofi_req_t req,
    input wire pofi_pkg::pofi_rsp_t rsp,
    input wire logic                flag_clr,
    input wire logic                boundary_error_flag_a,
    input wire logic                boundary_error_flag_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // every instruction answers exactly one edge later
    chk_done_after: assert property (req_valid |=> rsp.done)
        else $error("done missing after request");
    chk_done_idle: assert property (!req_valid |=> !rsp.done)
        else $error("done without request");
    chk_idle_zero: assert property (!req_valid |=> rsp.result == '0)
        else $error("result not zero when idle");
    // double copy of an immediate lands whole
    chk_copy_whole: assert property (req_valid && req.dbl && req.a_imm
        && req.op == pofi_pkg::OP_COPY
        |=> rsp.suppressed || rsp.result == $past(req.imm))
        else $error("double copy result wrong");
    // full product, no truncation to 16 bits
    chk_mul_full: assert property (req_valid && !req.sgn && req.a_imm
        && req.b_imm && req.op == pofi_pkg::OP_MUL |=> rsp.suppressed
        || rsp.result == $past(req.imm[15:0]) * $past(req.imm[15:0]))
        else $error("product wrong");
    // flags move together, stick until cleared
    chk_flag_pair: assert property (
        boundary_error_flag_a == boundary_error_flag_b)
        else $error("boundary flags differ");
    chk_supp_flags: assert property (rsp.suppressed
        |-> rsp.done && boundary_error_flag_a)
        else $error("suppressed without flag");
    chk_flag_sticky: assert property (boundary_error_flag_a && !flag_clr
        |=> boundary_error_flag_a)
        else $error("flag dropped by itself");
    chk_flag_clear: assert property (flag_clr
        |=> !boundary_error_flag_a || rsp.suppressed)
        else $error("flag not cleared");
    // contact moves only on its instruction
    chk_pulse_hold: assert property (
        !(req_valid && req.op == pofi_pkg::OP_PULSE)
        |=> $stable(rsp.contact_out))
        else $error("contact moved without pulse op");
    chk_pulse_low: assert property (req_valid && !req.contact_in
        && req.op == pofi_pkg::OP_PULSE |=> !rsp.contact_out)
        else $error("contact true with input off");
endmodule // pofi_unit_props

bind pofi_unit pofi_unit_props pofi_unit_props_i (.clk, .rst_n, .req_valid,
    .req, .rsp, .flag_clr, .boundary_error_flag_a, .boundary_error_flag_b);

// >>> sim/pofi_seq_model.sv
`timescale 1ns/10ps

// --------------------
// instruction sequencer model
// --------------------
module pofi_seq_model (
    input  wire logic           clk,
    output pofi_pkg::pofi_req_t req,
    output logic                req_valid
);
    // nothing issued before the bench asks
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // one instruction a cycle, back to back
    task automatic send(input pofi_pkg::pofi_req_t r);
        @(negedge clk);
        req_valid <= 1'b1;
        req       <= r;
    endtask

    // idle toggles fields; stale words are not trusted
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            req_valid <= 1'b0;
            req       <= ~req;
        end
    endtask
endmodule // pofi_seq_model

// >>> sim/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module testbench;
    typedef struct packed {logic c; logic s; logic [31:0] v;} pofi_exp_t;
    logic                  clk, rst_n, flag_clr, req_valid, bfa, bfb;
    logic [15:0]           peek_addr, peek_data, v;
    pofi_pkg::pofi_req_t   req, r;
    pofi_pkg::pofi_rsp_t   rsp;
    pofi_exp_t             q[$];
    int                    n_fail, tests_run, cyc;
    integer                seed = 32'h9906;
    pofi_pkg::pofi_op_t    bop[4] = '{pofi_pkg::OP_BADD, pofi_pkg::OP_BSUB,
                                      pofi_pkg::OP_BMUL, pofi_pkg::OP_BDIV};
    logic [31:0]           ba[4] = '{32'h9999_9999, 32'h1, 32'h1234_5678,
                                     32'h9999_9999};
    logic [31:0]           be[4] = '{32'h1, 32'h9999_9999, 32'h2469_1356,
                                     32'h4999_9999};

    pofi_unit #(.REG_DEPTH(64)) pofi_unit_i (.clk, .rst_n, .req_valid, .req,
        .rsp, .flag_clr, .boundary_error_flag_a(bfa),
        .boundary_error_flag_b(bfb), .peek_addr, .peek_data);
    pofi_seq_model pofi_seq_model_i (.clk, .req, .req_valid);

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // --------------------
    // helpers
    // --------------------
    function automatic pofi_pkg::pofi_req_t mk(pofi_pkg::pofi_op_t op,
        logic ai, logic [31:0] im, logic [15:0] ab = 0, logic [15:0] db = 0,
        logic d = 1);
        mk = '0;
        mk.op = op; mk.a_imm = ai; mk.b_imm = ai; mk.imm = im;
        mk.a_base = ab; mk.b_base = 16'h0032; mk.d_base = db; mk.dbl = d;
    endfunction

    // note the expectation, then issue
    task automatic go(pofi_pkg::pofi_req_t x, logic [31:0] e, logic s = 0,
        logic c = 0);
        q.push_back('{c, s, e});
        pofi_seq_model_i.send(x);
    endtask

    task automatic peek(logic [15:0] a, logic [15:0] e);
        @(negedge clk);
        peek_addr = a;
        @(negedge clk);
        `CHK("peek", e, peek_data)
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // done stands one cycle: look mid-cycle
    always @(negedge clk) begin : mon
        pofi_exp_t e;
        if (rsp.done === 1'b1) begin
            e = q.pop_front();
            `CHK("suppressed", e.s, rsp.suppressed)
            if (e.c) `CHK("contact", e.v[0], rsp.contact_out)
            else if (!e.s) `CHK("result", e.v, rsp.result)
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // --------------------
    // main sequence
    // --------------------
    initial begin
        rst_n = 1'b0; flag_clr = 1'b0; peek_addr = '0;
        n_fail = 0; tests_run = 0; cyc = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        // odd low register, read back next cycle
        go(mk(pofi_pkg::OP_COPY, 1, 32'h89ab_cdef, 0, 5), 32'h89ab_cdef);
        go(mk(pofi_pkg::OP_COPY, 0, 0, 5, 20), 32'h89ab_cdef);
        r = mk(pofi_pkg::OP_COPY, 0, 0, 6, 40, 0);
        r.sgn = 1;
        go(r, 32'hffff_89ab);
        r.sgn = 0;
        go(r, 32'h0000_89ab);
        pofi_seq_model_i.idle(2);
        peek(5, 16'hcdef);
        peek(6, 16'h89ab);
        $display("test pairing done");
        // load I:J and K, then indexed reads
        r = mk(pofi_pkg::OP_COPY, 1, 32'h0002_ffff);
        r.d_ixr = pofi_pkg::IX_I;
        go(r, 32'h0002_ffff);
        r = mk(pofi_pkg::OP_COPY, 1, 32'h3, 0, 0, 0);
        r.d_ixr = pofi_pkg::IX_K;
        go(r, 32'h3);
        r = mk(pofi_pkg::OP_COPY, 0, 0, 6, 41, 0);
        r.a_ix = pofi_pkg::IX_I;
        go(r, 32'h0000_cdef);
        r = mk(pofi_pkg::OP_COPY, 0, 0, 3, 42);
        r.a_ix = pofi_pkg::IX_J;
        go(r, 32'h89ab_cdef);
        r.a_base = 2; r.a_ix = pofi_pkg::IX_K;
        go(r, 32'h89ab_cdef);
        // out of area: below zero, pair past the top, double into K
        r = mk(pofi_pkg::OP_COPY, 0, 0, 0, 43, 0);
        r.a_ix = pofi_pkg::IX_I;
        go(r, 0, 1);
        go(mk(pofi_pkg::OP_COPY, 0, 0, 63, 44), 0, 1);
        r = mk(pofi_pkg::OP_COPY, 1, 32'h5);
        r.d_ixr = pofi_pkg::IX_K;
        go(r, 0, 1);
        pofi_seq_model_i.idle(2);
        `CHK("flag", 1'b1, bfa)
        flag_clr = 1'b1;
        @(negedge clk);
        flag_clr = 1'b0;
        @(negedge clk);
        `CHK("flag", 1'b0, bfb)
        $display("test index done");
        // increment writes back: second sees the first
        go(mk(pofi_pkg::OP_INC, 0, 0, 0, 20), 32'h89ab_cdf0);
        go(mk(pofi_pkg::OP_INC, 0, 0, 0, 20), 32'h89ab_cdf1);
        // random products, every top-bit position
        repeat (8) begin
            v = $random(seed);
            go(mk(pofi_pkg::OP_MUL, 1, {16'h0, v}, 0, 30),
               {16'h0, v} * {16'h0, v});
        end
        for (int p = 0; p < 16; p++) begin
            v = (16'h1 << p) | ($random(seed) & ((16'h1 << p) - 16'h1));
            go(mk(pofi_pkg::OP_HSB, 1, {16'h0, v}, 0, 45, 0), p);
        end
        $display("test arithmetic done");
        // bcd ops against 2 held in registers 50 and 51
        go(mk(pofi_pkg::OP_COPY, 1, 32'h2, 0, 50), 32'h2);
        for (int i = 0; i < 4; i++) begin
            r = mk(bop[i], 1, ba[i], 0, 46);
            r.b_imm = 1'b0;
            go(r, be[i]);
        end
        $display("test bcd done");
        // pulse contact over four scans
        for (int i = 0; i < 4; i++) begin
            r = mk(pofi_pkg::OP_PULSE, 0, 0);
            r.contact = 4'h3;
            r.contact_in = (i != 2);
            go(r, (i == 0 || i == 3), 0, 1);
            pofi_seq_model_i.idle(2);
        end
        $display("test pulse done");
        pofi_seq_model_i.idle(3);
        `CHK("queue left", 0, q.size())
        tally_and_finish();
    end
endmodule // testbench
